// ### design/sbuf_pkg.sv
// Constants, access sizes and states for the store buffer conflict unit.
// Assumes a 32-bit little-endian local memory port with byte-lane enables.
package sbuf_pkg;
  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int BE_W = 4;
  localparam int LANE_LSB = 2;
  // Bits compared when translation may alter the upper address
  localparam int XLAT_CMP_BITS = 10;
  // ----------------------------------------
  // Byte lanes and offsets
  // ----------------------------------------
  localparam logic [BE_W-1:0] BE_NONE = 4'h0;
  localparam logic [BE_W-1:0] BE_BYTE = 4'h1;
  localparam logic [BE_W-1:0] BE_HALF_LO = 4'h3;
  localparam logic [BE_W-1:0] BE_HALF_HI = 4'hC;
  localparam logic [BE_W-1:0] BE_WORD = 4'hF;
  localparam logic [1:0] HALF_OFFSET = 2'h2;
  localparam int HALF_STEP_BYTES = 2;
  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    SIZE_BYTE = 2'b00,
    SIZE_HALF = 2'b01,
    SIZE_WORD = 2'b10
  } access_size_type;
  typedef enum logic [0:0] {
    ST_RUN = 1'b0,
    ST_WRAP = 1'b1
  } lsu_state_type;
endpackage : sbuf_pkg

// ### design/store_buffer_conflict_unit.sv
// Single-entry store buffer with load conflict detection for the load-store pipe.
// Assumes decode holds a load steady until o_ld_ready, and the execute stage
// never stalls a store.
//
// How it works
// - Loads reach memory from decode stage, stores from execute stage.
// - Store followed by decode-stage load goes into buffer; load goes first.
// - Buffered store commits on next local store or a cycle without memory access.
// - Only local data RAM or data cache stores may enter the buffer.
// - Bus-memory stores issue at once, in order, bypassing the buffer.
// - Any byte of a load overlapping buffered data flags a conflict.
// - Conflict cancels the load, drains the buffer, then the load retries.
// - Translation on and either side translated: compare address bits 9..0 only.
// - Without translation compare the complete address.
// - Wrapping half-aligned circular word load splits: buffer top, then base.
// - Second wrapped access of a split load is also conflict checked.
`timescale 1ns/1ps
module store_buffer_conflict_unit #(
  parameter int ADDR_W = sbuf_pkg::ADDR_W
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // Translation control
  input wire logic i_mmu_en,
  // Load in decode stage
  input wire logic i_ld_valid,
  input wire logic [ADDR_W-1:0] i_ld_addr,
  input wire sbuf_pkg::access_size_type i_ld_size,
  input wire logic i_ld_xlat,
  input wire logic i_ld_circ,
  input wire logic [ADDR_W-1:0] i_ld_cbuf_base,
  input wire logic [ADDR_W-1:0] i_ld_cbuf_end,
  output logic o_ld_ready,
  output logic o_ld_cancel,
  // Store in execute stage
  input wire logic i_st_valid,
  input wire logic [ADDR_W-1:0] i_st_addr,
  input wire logic [sbuf_pkg::BE_W-1:0] i_st_be,
  input wire logic [sbuf_pkg::DATA_W-1:0] i_st_data,
  input wire logic i_st_local,
  input wire logic i_st_xlat,
  // Local memory port
  output logic o_mem_req,
  output logic o_mem_we,
  output logic [ADDR_W-1:0] o_mem_addr,
  output logic [sbuf_pkg::BE_W-1:0] o_mem_be,
  output logic [sbuf_pkg::DATA_W-1:0] o_mem_wdata,
  output logic o_mem_wrapped,
  // Bus memory store port
  output logic o_bus_req,
  output logic [ADDR_W-1:0] o_bus_addr,
  output logic [sbuf_pkg::BE_W-1:0] o_bus_be,
  output logic [sbuf_pkg::DATA_W-1:0] o_bus_wdata
);
  import sbuf_pkg::*;

  localparam logic [ADDR_W-1:0] ADDR_ZERO = '0;
  localparam logic [ADDR_W-1:0] HALF_STEP = ADDR_W'(HALF_STEP_BYTES);
  localparam logic [ADDR_W-1:0] XLAT_MASK = ADDR_W'((64'h1 << XLAT_CMP_BITS) - 64'h1);
  localparam logic [ADDR_W-1:0] FULL_MASK = '1;
  localparam logic [ADDR_W-1:0] WORD_MASK = ~ADDR_W'((64'h1 << LANE_LSB) - 64'h1);

  // ----------------------------------------
  // Decoding helpers
  // ----------------------------------------
  function automatic logic [BE_W-1:0] lane_mask(input logic [1:0] offs, input access_size_type size);
    logic [BE_W-1:0] base_mask;
    base_mask = BE_BYTE;
    case (size)
      SIZE_BYTE: base_mask = BE_BYTE;
      SIZE_HALF: base_mask = BE_HALF_LO;
      SIZE_WORD: base_mask = BE_WORD;
      default: base_mask = BE_NONE;
    endcase
    lane_mask = BE_W'(base_mask << offs);
  endfunction : lane_mask

  // mask picks compared bits
  // Truncated compare may report false conflicts; that only costs a drain
  function automatic logic lanes_overlap(
    input logic [ADDR_W-1:0] st_a, input logic [BE_W-1:0] st_be, input logic st_x,
    input logic [ADDR_W-1:0] ld_a, input logic [BE_W-1:0] ld_be, input logic ld_x,
    input logic mmu);
    logic [ADDR_W-1:0] mask;
    mask = (mmu && (st_x || ld_x)) ? (XLAT_MASK & WORD_MASK) : (FULL_MASK & WORD_MASK);
    lanes_overlap = (((st_a ^ ld_a) & mask) == ADDR_ZERO) && ((st_be & ld_be) != BE_NONE);
  endfunction : lanes_overlap

  // ----------------------------------------
  // Buffer entry and state
  // ----------------------------------------
  logic buf_valid;
  logic [ADDR_W-1:0] buf_addr;
  logic [BE_W-1:0] buf_be;
  logic [DATA_W-1:0] buf_data;
  logic buf_xlat;
  lsu_state_type state;

  logic st_local;
  logic split;
  logic [ADDR_W-1:0] ld_addr_cur;
  logic [BE_W-1:0] ld_be_cur;
  logic conflict;
  logic buf_take;
  logic buf_free;
  logic ld_step;
  logic next_req;
  logic next_we;
  logic [ADDR_W-1:0] next_addr;
  logic [BE_W-1:0] next_be;
  logic [DATA_W-1:0] next_wdata;
  logic next_wrapped;

  assign st_local = i_st_valid && i_st_local;
  assign split = i_ld_circ && (i_ld_size == SIZE_WORD) && (i_ld_addr[1:0] == HALF_OFFSET)
                 && ((i_ld_addr + HALF_STEP) == i_ld_cbuf_end);
  assign ld_addr_cur = (state == ST_WRAP) ? i_ld_cbuf_base : i_ld_addr;
  assign ld_be_cur = (state == ST_WRAP) ? BE_HALF_LO : (split ? BE_HALF_HI : lane_mask(i_ld_addr[1:0], i_ld_size));
  assign conflict = i_ld_valid && buf_valid
                    && lanes_overlap(buf_addr, buf_be, buf_xlat, ld_addr_cur, ld_be_cur, i_ld_xlat, i_mmu_en);

  // ----------------------------------------
  // Port arbitration
  // ----------------------------------------
  always_comb begin
    next_req = 1'b0;
    next_we = 1'b0;
    next_addr = o_mem_addr;
    next_be = o_mem_be;
    next_wdata = o_mem_wdata;
    next_wrapped = 1'b0;
    buf_take = 1'b0;
    buf_free = 1'b0;
    ld_step = 1'b0;
    if (conflict) begin
      next_req = 1'b1;
      next_we = 1'b1;
      next_addr = buf_addr & WORD_MASK;
      next_be = buf_be;
      next_wdata = buf_data;
      buf_free = 1'b1;
      buf_take = st_local;
    end else if (i_ld_valid && st_local && buf_valid) begin
      next_req = 1'b1;
      next_we = 1'b1;
      next_addr = buf_addr & WORD_MASK;
      next_be = buf_be;
      next_wdata = buf_data;
      buf_take = 1'b1;
    end else if (i_ld_valid) begin
      next_req = 1'b1;
      next_addr = ld_addr_cur & WORD_MASK;
      next_be = ld_be_cur;
      next_wrapped = (state == ST_WRAP);
      ld_step = 1'b1;
      buf_take = st_local;
    end else if (st_local) begin
      next_req = 1'b1;
      next_we = 1'b1;
      if (buf_valid) begin
        next_addr = buf_addr & WORD_MASK;
        next_be = buf_be;
        next_wdata = buf_data;
        buf_take = 1'b1;
      end else begin
        next_addr = i_st_addr & WORD_MASK;
        next_be = i_st_be;
        next_wdata = i_st_data;
      end
    end else if (buf_valid) begin
      next_req = 1'b1;
      next_we = 1'b1;
      next_addr = buf_addr & WORD_MASK;
      next_be = buf_be;
      next_wdata = buf_data;
      buf_free = 1'b1;
    end
  end

  assign o_ld_ready = ld_step && ((state == ST_WRAP) || !split);
  assign o_ld_cancel = conflict;

  // ----------------------------------------
  // Buffer entry
  // ----------------------------------------
  // only local stores are taken
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      buf_valid <= 1'b0;
      buf_addr <= ADDR_ZERO;
      buf_be <= BE_NONE;
      buf_data <= DATA_ZERO;
      buf_xlat <= 1'b0;
    end else if (buf_take) begin
      buf_valid <= 1'b1;
      buf_addr <= i_st_addr;
      buf_be <= i_st_be;
      buf_data <= i_st_data;
      buf_xlat <= i_st_xlat;
    end else if (buf_free) begin
      buf_valid <= 1'b0;
    end
  end

  // ----------------------------------------
  // Split load sequencing
  // ----------------------------------------
  // top first, then base
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      state <= ST_RUN;
    end else begin
      case (state)
        ST_RUN: begin
          if (ld_step && split) begin
            state <= ST_WRAP;
          end
        end
        ST_WRAP: begin
          if (ld_step) begin
            state <= ST_RUN;
          end
        end
        default: state <= ST_RUN;
      endcase
    end
  end

  // ----------------------------------------
  // Memory and bus ports
  // ----------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_mem_req <= 1'b0;
      o_mem_we <= 1'b0;
      o_mem_addr <= ADDR_ZERO;
      o_mem_be <= BE_NONE;
      o_mem_wdata <= DATA_ZERO;
      o_mem_wrapped <= 1'b0;
    end else begin
      o_mem_req <= next_req;
      o_mem_we <= next_we;
      o_mem_addr <= next_addr;
      o_mem_be <= next_be;
      o_mem_wdata <= next_wdata;
      o_mem_wrapped <= next_wrapped;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_bus_req <= 1'b0;
      o_bus_addr <= ADDR_ZERO;
      o_bus_be <= BE_NONE;
      o_bus_wdata <= DATA_ZERO;
    end else begin
      o_bus_req <= i_st_valid && !i_st_local;
      if (i_st_valid && !i_st_local) begin
        o_bus_addr <= i_st_addr;
        o_bus_be <= i_st_be;
        o_bus_wdata <= i_st_data;
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  sequence s_drain_then_retry;
    (o_mem_req && o_mem_we && !buf_valid) ##1 (o_mem_req && !o_mem_we);
  endsequence

  sequence s_split_pair(logic [ADDR_W-1:0] top, logic [ADDR_W-1:0] base);
    (o_mem_req && !o_mem_we && o_mem_addr == (top & WORD_MASK) && o_mem_be == BE_HALF_HI && !o_mem_wrapped)
    ##1
    (o_mem_req && !o_mem_we && o_mem_addr == (base & WORD_MASK) && o_mem_be == BE_HALF_LO && o_mem_wrapped);
  endsequence

  a_load_from_decode: assert property (
    (i_ld_valid && !buf_valid && !o_ld_cancel) |=> (o_mem_req && !o_mem_we && o_mem_addr == $past(ld_addr_cur & WORD_MASK)))
    else $error("load not issued from decode");
  a_store_parked: assert property (
    (i_ld_valid && st_local && !buf_valid) |=> (buf_valid && o_mem_req && !o_mem_we && buf_addr == $past(i_st_addr)))
    else $error("store not parked behind load");
  a_idle_drain: assert property (
    (buf_valid && !i_ld_valid && !i_st_valid) |=> (o_mem_we && o_mem_be == $past(buf_be) && !buf_valid))
    else $error("buffer not drained on idle cycle");
  a_nonlocal_bypass: assert property (
    (i_st_valid && !i_st_local && !buf_valid) |=> !buf_valid)
    else $error("bus store entered buffer");
  a_bus_store_now: assert property (
    (i_st_valid && !i_st_local) |=> (o_bus_req && o_bus_addr == $past(i_st_addr) && o_bus_wdata == $past(i_st_data)))
    else $error("bus store delayed");
  a_partial_overlap: assert property (
    (i_ld_valid && buf_valid && state == ST_RUN && !split && !i_mmu_en
     && (buf_addr & WORD_MASK) == (i_ld_addr & WORD_MASK)
     && (buf_be & lane_mask(i_ld_addr[1:0], i_ld_size)) != BE_NONE) |-> o_ld_cancel)
    else $error("overlap missed");
  a_cancel_drain: assert property (
    (o_ld_cancel && !st_local) |=> s_drain_then_retry)
    else $error("conflict not drained and retried");
  a_xlat_low_bits: assert property (
    (i_ld_valid && buf_valid && state == ST_RUN && !split && i_mmu_en && (buf_xlat || i_ld_xlat)
     && ((buf_addr ^ i_ld_addr) & XLAT_MASK & WORD_MASK) == ADDR_ZERO
     && (buf_be & lane_mask(i_ld_addr[1:0], i_ld_size)) != BE_NONE) |-> o_ld_cancel)
    else $error("translated compare too wide");
  a_full_compare: assert property (
    (!i_mmu_en && ((buf_addr ^ ld_addr_cur) & WORD_MASK) != ADDR_ZERO) |-> !o_ld_cancel)
    else $error("false conflict on full address");
  a_split_order: assert property (
    (state == ST_RUN && i_ld_valid && split && !o_ld_cancel && !(st_local && buf_valid)) ##1 o_ld_ready
    |-> s_split_pair($past(i_ld_addr), $past(i_ld_cbuf_base)))
    else $error("split order wrong");
  a_wrap_conflict: assert property (
    (state == ST_WRAP && i_ld_valid && buf_valid && !i_mmu_en
     && (buf_addr & WORD_MASK) == (i_ld_cbuf_base & WORD_MASK)
     && (buf_be & BE_HALF_LO) != BE_NONE) |-> (o_ld_cancel && !o_ld_ready))
    else $error("wrapped access overtook store");
  a_lane_disjoint: assert property (
    (buf_valid && (buf_be & ld_be_cur) == BE_NONE) |-> !o_ld_cancel)
    else $error("conflict without shared lane");
endmodule : store_buffer_conflict_unit

// ### tb/local_mem_model.sv
// Local data RAM model behind the memory port of the unit.
// Assumes word addresses inside one 256-byte window.
`timescale 1ns/1ps
module local_mem_model (
  // Memory port from the unit
  input wire logic i_clk_sys,
  input wire logic i_req,
  input wire logic i_we,
  input wire logic [31:0] i_addr,
  input wire logic [3:0] i_be,
  input wire logic [31:0] i_wdata,
  // Read data
  output logic [31:0] o_rdata
);
  logic [31:0] mem [64];
  // Idle bus shows inverse, never the last word
  assign o_rdata = (i_req && !i_we) ? mem[i_addr[7:2]] : ~mem[i_addr[7:2]];
  initial begin
    for (int i = 0; i < 64; i++) begin
      mem[i] = 32'h0;
    end
  end
  // Byte-lane writes only
  always @(posedge i_clk_sys) begin
    for (int b = 0; b < 4; b++) begin
      if (i_req && i_we && i_be[b]) begin
        mem[i_addr[7:2]][8*b+:8] <= i_wdata[8*b+:8];
      end
    end
  end
endmodule : local_mem_model

// ### tb/store_buffer_conflict_unit_bench.sv
// Self-checking bench for the store buffer conflict unit.
// Assumes a local RAM model on the memory port; the bus port is observed only.
`timescale 1ns/1ps
module store_buffer_conflict_unit_bench;
  import sbuf_pkg::*;
  logic i_clk_sys, i_rst_n, i_mmu_en, i_ld_valid, i_ld_xlat, i_ld_circ;
  logic [31:0] i_ld_addr, i_ld_cbuf_base, i_ld_cbuf_end, i_st_addr, i_st_data;
  access_size_type i_ld_size;
  logic i_st_valid, i_st_local, i_st_xlat, ld_taken, wrote;
  logic [3:0] i_st_be, o_mem_be, o_bus_be;
  logic o_ld_ready, o_ld_cancel, o_mem_req, o_mem_we, o_mem_wrapped, o_bus_req;
  logic [31:0] o_mem_addr, o_mem_wdata, o_bus_addr, o_bus_wdata, rdata, msk, base, lim;
  logic [31:0] mirror [64];
  logic [1:0] sz;
  int bad_count = 0, samples_checked = 0, cycles = 0, j, w, off, wraps;
  logic [3:0] be_tab [7] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hC, 4'hF};
  logic [1:0] lo_tab [7] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h2, 2'h0};

  store_buffer_conflict_unit uut (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_mmu_en(i_mmu_en),
    .i_ld_valid(i_ld_valid), .i_ld_addr(i_ld_addr), .i_ld_size(i_ld_size), .i_ld_xlat(i_ld_xlat),
    .i_ld_circ(i_ld_circ), .i_ld_cbuf_base(i_ld_cbuf_base), .i_ld_cbuf_end(i_ld_cbuf_end),
    .o_ld_ready(o_ld_ready), .o_ld_cancel(o_ld_cancel), .i_st_valid(i_st_valid), .i_st_addr(i_st_addr),
    .i_st_be(i_st_be), .i_st_data(i_st_data), .i_st_local(i_st_local), .i_st_xlat(i_st_xlat),
    .o_mem_req(o_mem_req), .o_mem_we(o_mem_we), .o_mem_addr(o_mem_addr), .o_mem_be(o_mem_be),
    .o_mem_wdata(o_mem_wdata), .o_mem_wrapped(o_mem_wrapped), .o_bus_req(o_bus_req),
    .o_bus_addr(o_bus_addr), .o_bus_be(o_bus_be), .o_bus_wdata(o_bus_wdata));
  local_mem_model ram (.i_clk_sys(i_clk_sys), .i_req(o_mem_req), .i_we(o_mem_we), .i_addr(o_mem_addr),
    .i_be(o_mem_be), .i_wdata(o_mem_wdata), .o_rdata(rdata));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict
  task automatic step(input logic st);
    @(negedge i_clk_sys);
    i_st_valid = st;
  endtask : step
  task automatic st_fields(input logic [31:0] a, input logic [3:0] be, input logic loc);
    i_st_addr = a;
    i_st_be = be;
    i_st_data = $urandom;
    i_st_local = loc;
  endtask : st_fields
  task automatic set_ld(input logic [31:0] a, input logic [1:0] s, input logic c, input logic [31:0] b,
      input logic [31:0] e);
    i_ld_valid = 1'h1;
    i_ld_addr = a;
    i_ld_size = access_size_type'(s);
    i_ld_circ = c;
    i_ld_cbuf_base = b;
    i_ld_cbuf_end = e;
  endtask : set_ld

  initial begin
    i_clk_sys = 1'h0;
    forever #10 i_clk_sys = ~i_clk_sys;
  end
  // Program-order mirror; timeout guard
  always @(posedge i_clk_sys) begin
    ld_taken <= i_ld_valid && o_ld_ready;
    cycles <= cycles + 1;
    for (int b = 0; b < 4; b++) begin
      if (i_rst_n && i_st_valid && i_st_local && i_st_be[b]) mirror[i_st_addr[7:2]][8*b+:8] <= i_st_data[8*b+:8];
    end
    if (cycles == 3000) begin
      bad_count++;
      give_verdict();
    end
  end
  always @(negedge i_clk_sys) begin
    if (i_rst_n && o_mem_req && !o_mem_we && o_mem_addr[31:8] == 24'h000010) begin
      msk = {{8{o_mem_be[3]}}, {8{o_mem_be[2]}}, {8{o_mem_be[1]}}, {8{o_mem_be[0]}}};
      chk(rdata & msk, mirror[o_mem_addr[7:2]] & msk);
    end
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    for (int i = 0; i < 64; i++) mirror[i] = 32'h0;
    void'($urandom(4));
    {i_rst_n, i_mmu_en, i_ld_valid, i_ld_xlat, i_ld_circ, i_st_valid, i_st_local, i_st_xlat} = 8'h00;
    {i_ld_addr, i_ld_cbuf_base, i_ld_cbuf_end, i_st_addr, i_st_data, i_st_be} = '0;
    i_ld_size = SIZE_WORD;
    repeat (3) @(negedge i_clk_sys);
    i_rst_n = 1'h1;
    step(1'h0);
    step(1'h1);
    st_fields(32'h1000, 4'hF, 1'h1);
    set_ld(32'h1010, 2'h2, 1'h0, 32'h0, 32'h0);
    #1 chk(o_ld_ready, 1'h1);
    step(1'h0);
    i_ld_valid = 1'h0;
    chk({o_mem_req, o_mem_we}, 2'h2);
    chk(o_mem_addr, 32'h1010);
    step(1'h0);
    chk({o_mem_req, o_mem_we}, 2'h3);
    chk(o_mem_addr, 32'h1000);
    step(1'h1);
    st_fields(32'h1001, 4'h2, 1'h1);
    set_ld(32'h1020, 2'h2, 1'h0, 32'h0, 32'h0);
    step(1'h0);
    set_ld(32'h1002, 2'h1, 1'h0, 32'h0, 32'h0);
    #1 chk({o_ld_ready, o_ld_cancel}, 2'h2);
    step(1'h0);
    set_ld(32'h1000, 2'h2, 1'h0, 32'h0, 32'h0);
    #1 chk({o_ld_ready, o_ld_cancel}, 2'h1);
    step(1'h0);
    #1 chk({o_mem_we, o_mem_be, o_ld_ready}, 6'h25);
    step(1'h0);
    i_ld_valid = 1'h0;
    step(1'h1);
    st_fields(32'h1004, 4'hF, 1'h1);
    set_ld(32'h1020, 2'h2, 1'h0, 32'h0, 32'h0);
    step(1'h0);
    i_ld_xlat = 1'h1;
    set_ld(32'h0040_1004, 2'h2, 1'h0, 32'h0, 32'h0);
    #1 chk({o_ld_ready, o_ld_cancel}, 2'h2);
    step(1'h0);
    i_mmu_en = 1'h1;
    #1 chk({o_ld_ready, o_ld_cancel}, 2'h1);
    step(1'h0);
    step(1'h0);
    {i_ld_valid, i_mmu_en, i_ld_xlat} = 3'h0;
    // Translated store in the buffer, plain load
    step(1'h1);
    i_st_xlat = 1'h1;
    st_fields(32'h1004, 4'h3, 1'h1);
    set_ld(32'h1020, 2'h2, 1'h0, 32'h0, 32'h0);
    step(1'h0);
    {i_mmu_en, i_st_xlat} = 2'h2;
    set_ld(32'h0080_1005, 2'h0, 1'h0, 32'h0, 32'h0);
    #1 chk({o_ld_ready, o_ld_cancel}, 2'h1);
    step(1'h0);
    step(1'h0);
    {i_ld_valid, i_mmu_en} = 2'h0;
    // Wrap cases: base low bits 0x8 and 0x0, then a lane-disjoint store
    for (int k = 0; k < 3; k++) begin
      base = (k == 1) ? 32'h1000 : 32'h1008;
      lim = (k == 1) ? 32'h1014 : 32'h1018;
      step(1'h1);
      st_fields(base + ((k == 2) ? 32'h2 : 32'h1), (k == 2) ? 4'h4 : 4'h2, 1'h1);
      set_ld(32'h1020, 2'h2, 1'h0, 32'h0, 32'h0);
      step(1'h0);
      set_ld(lim - 32'h2, 2'h2, 1'h1, base, lim);
      wrote = 1'h0;
      wraps = 0;
      for (int c = 0; c < 8; c++) begin
        step(1'h0);
        if (ld_taken) i_ld_valid = 1'h0;
        if (o_mem_req && o_mem_we && o_mem_addr == base) wrote = 1'h1;
        if (o_mem_req && !o_mem_we && o_mem_addr == lim - 32'h4) chk(o_mem_be, 4'hC);
        if (o_mem_req && o_mem_wrapped) begin
          wraps++;
          chk({o_mem_we, o_mem_be, wrote}, {5'h03, 1'(k != 2)});
          chk(o_mem_addr, base);
        end
      end
      chk(wraps, 32'h1);
    end
    step(1'h1);
    st_fields(32'h2000_0004, 4'hF, 1'h0);
    set_ld(32'h1020, 2'h2, 1'h0, 32'h0, 32'h0);
    step(1'h0);
    i_ld_valid = 1'h0;
    chk({o_bus_req, o_bus_be, o_mem_we}, 6'h3E);
    chk(o_bus_addr, 32'h2000_0004);
    chk(o_bus_wdata, i_st_data);
    step(1'h0);
    chk({o_bus_req, o_mem_req}, 2'h0);
    // Random traffic; same-word store beside a live load is avoided
    for (int n = 0; n < 400; n++) begin
      step(1'($urandom % 2));
      if (ld_taken || !i_ld_valid) begin
        sz = 2'($urandom % 3);
        off = (sz == 2'h2) ? 0 : (sz == 2'h1) ? 2 * ($urandom % 2) : $urandom % 4;
        if ($urandom % 2) set_ld(32'h1000 + 4 * ($urandom % 8) + off, sz, 1'h0, 32'h0, 32'h0);
        else i_ld_valid = 1'h0;
      end
      w = $urandom % 8;
      j = $urandom % 7;
      if (i_ld_valid && w == i_ld_addr[4:2]) w = w ^ 1;
      st_fields(32'h1000 + 4 * w + lo_tab[j], be_tab[j], 1'($urandom % 4 != 0));
    end
    step(1'h0);
    i_ld_valid = 1'h0;
    repeat (4) step(1'h0);
    give_verdict();
  end
endmodule : store_buffer_conflict_unit_bench
